// ---- rtl/pxc_regs.sv ----
/*
 * control logic behind the test extension and general control two registers.
 * assumes a management engine that presents decoded write strobes and read
 * addresses synchronous to mclk, and a local phy address from straps.
 */
`timescale 1ns/100ps
`include "pxc_consts.svh"
module pxc_regs (
    input  wire logic           mclk,           // 10 MHz reference clock
    input  wire logic           rst,            // synchronous reset, active high
    input  wire logic           strap_clkout_dis, // strap for clock output disable
    input  wire logic [4:0]     local_phyad,    // local phy address
    input  pxc_pkg::pxc_mgmt_wr_t mgmt_wr,      // management write
    input  wire logic [4:0]     rd_regad,       // management read address
    output logic [15:0]         rd_data,        // read data
    output logic                rd_hit,         // read address maps here
    input  pxc_pkg::pxc_link_stat_t link_stat,  // speed and mac mode
    output pxc_pkg::pxc_ctrl_t  ctrl,           // control toward device
    output logic                soft_reset_out  // device logic reset, high
);
    import pxc_pkg::*;

    // test extension register state
    logic       pat_en_r;       // pattern_enable_10m
    logic       pat_en_nxt;
    logic [1:0] pat_sel_r;      // test_pattern_select
    logic [1:0] pat_sel_nxt;
    // general control two state
    logic       sync_r;         // sync_tx_to_rx_clock_enable
    logic       sync_nxt;
    logic       rclk_out_r;     // recovered_clock_out_select
    logic       rclk_out_nxt;
    logic       bcast_r;        // broadcast_write_enable
    logic       bcast_nxt;
    logic       legacy_r;       // legacy pinout mode
    logic       legacy_nxt;
    logic       clkdis_r;       // clock_output_disable
    logic       clkdis_nxt;
    logic       rsvd0_r;        // reserved read-write bit 0
    logic       rsvd0_nxt;
    logic       strap_pend_r;   // strap still to be caught after reset
    logic       strap_pend_nxt;
    // soft reset sequencer
    logic       srst_bit_r;     // soft reset bit as read back
    logic       srst_bit_nxt;
    logic [3:0] srst_cnt_r;     // remaining reset cycles
    logic [3:0] srst_cnt_nxt;
    // output flops
    pxc_ctrl_t  ctrl_r;
    pxc_ctrl_t  ctrl_nxt;
    logic [15:0] rd_data_r;
    logic [15:0] rd_data_nxt;

    // address decode of a write
    logic       wr_addr_ok;     // frame addressed to us
    logic       wr_test;        // write hits test extension
    logic       wr_gen;         // write hits general control two

    // write address match
    always_comb
    begin
        wr_addr_ok = (mgmt_wr.phyad == local_phyad) ||
                     (bcast_r && (mgmt_wr.phyad == `PXC_BCAST_PHYAD));
        wr_test    = mgmt_wr.wr && wr_addr_ok && (mgmt_wr.regad == `PXC_ADDR_TEST_EXT);
        wr_gen     = mgmt_wr.wr && wr_addr_ok && (mgmt_wr.regad == `PXC_ADDR_GEN_CTRL2);
    end

    // next values of the register fields
    always_comb
    begin
        pat_en_nxt     = pat_en_r;
        pat_sel_nxt    = pat_sel_r;
        sync_nxt       = sync_r;
        rclk_out_nxt   = rclk_out_r;
        bcast_nxt      = bcast_r;
        legacy_nxt     = legacy_r;
        clkdis_nxt     = clkdis_r;
        rsvd0_nxt      = rsvd0_r;
        strap_pend_nxt = 1'b0;
        if (strap_pend_r)
        begin
            clkdis_nxt = strap_clkout_dis;
        end
        if (wr_test)
        begin
            pat_en_nxt  = mgmt_wr.data[`PXC_TP_EN_BIT];
            pat_sel_nxt = mgmt_wr.data[`PXC_TP_SEL_LSB +: 2];
        end
        if (wr_gen)
        begin
            sync_nxt     = mgmt_wr.data[`PXC_SYNC_BIT];
            rclk_out_nxt = mgmt_wr.data[`PXC_RCLK_OUT_BIT];
            bcast_nxt    = mgmt_wr.data[`PXC_BCAST_BIT];
            legacy_nxt   = mgmt_wr.data[`PXC_LEGACY_BIT];
            clkdis_nxt   = mgmt_wr.data[`PXC_CLKDIS_BIT];
            // stored as written, software keeps zero
            rsvd0_nxt    = mgmt_wr.data[`PXC_RSVD0_BIT];
        end
    end

    // register fields, kept through soft reset
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pat_en_r     <= 1'b0;
            pat_sel_r    <= `PXC_TP_SEL_RST;
            sync_r       <= 1'b0;
            rclk_out_r   <= 1'b0;
            bcast_r      <= 1'b0;
            legacy_r     <= 1'b0;
            clkdis_r     <= 1'b0;
            rsvd0_r      <= 1'b0;
            strap_pend_r <= 1'b1;
        end
        else
        begin
            pat_en_r     <= pat_en_nxt;
            pat_sel_r    <= pat_sel_nxt;
            sync_r       <= sync_nxt;
            rclk_out_r   <= rclk_out_nxt;
            bcast_r      <= bcast_nxt;
            legacy_r     <= legacy_nxt;
            clkdis_r     <= clkdis_nxt;
            rsvd0_r      <= rsvd0_nxt;
            strap_pend_r <= strap_pend_nxt;
        end
    end

    // soft reset sequencer next state
    always_comb
    begin
        srst_cnt_nxt = srst_cnt_r;
        srst_bit_nxt = srst_bit_r;
        if (srst_cnt_r != 4'h0)
        begin
            srst_cnt_nxt = srst_cnt_r - 4'h1;
            if (srst_cnt_r == 4'h1)
            begin
                srst_bit_nxt = 1'b0;
            end
        end
        else if (wr_gen && mgmt_wr.data[`PXC_SRST_BIT])
        begin
            srst_cnt_nxt = `PXC_SRST_CYCLES;
            srst_bit_nxt = 1'b1;
        end
    end

    // soft reset sequencer flops
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            srst_cnt_r <= 4'h0;
            srst_bit_r <= 1'b0;
        end
        else
        begin
            srst_cnt_r <= srst_cnt_nxt;
            srst_bit_r <= srst_bit_nxt;
        end
    end

    // control outputs from the stored fields
    always_comb
    begin
        ctrl_nxt.pattern_enable_10m  = pat_en_r;
        ctrl_nxt.test_pattern_select = pat_en_r ? pat_sel_r : `PXC_TP_SEL_RST;
        ctrl_nxt.tx_clk_from_rx = sync_r && link_stat.speed_100 && link_stat.mac_mii_rmii_master;
        ctrl_nxt.clkout_from_rx = rclk_out_r && link_stat.speed_100;
        ctrl_nxt.clkout_enable  = legacy_r || !clkdis_r;
        ctrl_nxt.legacy_pinout  = legacy_r;
        ctrl_nxt.broadcast_write_enable = bcast_r;
    end

    // read data mux
    always_comb
    begin
        rd_data_nxt = 16'h0000;
        case (rd_regad)
            `PXC_ADDR_TEST_EXT:
            begin
                rd_data_nxt[`PXC_TP_EN_BIT]      = pat_en_r;
                rd_data_nxt[`PXC_TP_SEL_LSB +: 2] = pat_sel_r;
            end
            `PXC_ADDR_GEN_CTRL2:
            begin
                rd_data_nxt[`PXC_SYNC_BIT]     = sync_r;
                rd_data_nxt[`PXC_RCLK_OUT_BIT] = rclk_out_r;
                rd_data_nxt[`PXC_BCAST_BIT]    = bcast_r;
                rd_data_nxt[`PXC_LEGACY_BIT]   = legacy_r;
                rd_data_nxt[`PXC_SRST_BIT]     = srst_bit_r;
                rd_data_nxt[`PXC_CLKDIS_BIT]   = clkdis_r;
                rd_data_nxt[`PXC_RSVD0_BIT]    = rsvd0_r;
            end
            default:
            begin
                rd_data_nxt = 16'h0000;
            end
        endcase
    end

    // output registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_r    <= '0;
            rd_data_r <= 16'h0000;
        end
        else
        begin
            ctrl_r    <= ctrl_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign ctrl           = ctrl_r;
    assign rd_data        = rd_data_r;
    assign rd_hit         = (rd_regad == `PXC_ADDR_TEST_EXT) || (rd_regad == `PXC_ADDR_GEN_CTRL2);
    assign soft_reset_out = srst_bit_r;
endmodule : pxc_regs

// ---- rtl/pxc_consts.svh ----
/*
 * register offsets, field positions, reset values and timing counts for the
 * extended control register pair.
 * assumes inclusion by bare name from the design file.
 */
`ifndef PXC_CONSTS_SVH
`define PXC_CONSTS_SVH

// register offsets on the management port
`define PXC_ADDR_TEST_EXT     5'h1b
`define PXC_ADDR_GEN_CTRL2    5'h1c
// broadcast phy address
`define PXC_BCAST_PHYAD       5'h1f

// test extension fields
`define PXC_TP_SEL_LSB        0
`define PXC_TP_EN_BIT         4
`define PXC_TP_SEL_RST        2'h0

// general control two fields
`define PXC_SYNC_BIT          13
`define PXC_RCLK_OUT_BIT      12
`define PXC_BCAST_BIT         11
`define PXC_LEGACY_BIT        10
`define PXC_SRST_BIT          9
`define PXC_CLKDIS_BIT        1
`define PXC_RSVD0_BIT         0

// soft reset pulse length in reference clocks
`define PXC_SRST_CYCLES       4'h8

`endif

// ---- rtl/pxc_pkg.sv ----
/*
 * types shared by the extended control register block.
 * assumes pxc_consts.svh is on the include path.
 */
package pxc_pkg;
    // test pattern choices
    typedef enum logic [1:0] {
        PXC_PAT_DATA_EOP_A = 2'h0, // data, end_of_packet_variant_a
        PXC_PAT_DATA_EOP_B = 2'h1, // data, end_of_packet_variant_b
        PXC_PAT_LINK_PULSE = 2'h2, // link pulses
        PXC_PAT_MANCH_ONES = 2'h3  // constant manchester ones
    } pxc_pattern_t;

    // management write strobe with address and data
    typedef struct packed {
        logic        wr;    // one-cycle write strobe
        logic [4:0]  phyad; // phy address of the frame
        logic [4:0]  regad; // register address
        logic [15:0] data;  // write data
    } pxc_mgmt_wr_t;

    // device status feeding the clock decisions
    typedef struct packed {
        logic speed_100;    // link runs at 100 Mb/s
        logic mac_mii_rmii_master; // mac interface is mii or rmii master
    } pxc_link_stat_t;

    // control outputs toward the rest of the device
    typedef struct packed {
        logic       pattern_enable_10m;  // 10 Mb test pattern on
        logic [1:0] test_pattern_select; // chosen pattern
        logic       tx_clk_from_rx;      // transmit follows recovered clock
        logic       clkout_from_rx;      // clock pin carries recovered clock
        logic       clkout_enable;       // clock pin drives
        logic       legacy_pinout;       // legacy pin and strap order
        logic       broadcast_write_enable; // accept writes to phy 0x1f
    } pxc_ctrl_t;
endpackage : pxc_pkg

// ---- test/pxc_mgmt_model.sv ----
/* management station model: one-cycle writes, registered reads.
   assumes calls at a falling edge of mclk. */
`timescale 1ns/100ps
module pxc_mgmt_model (
    input  wire logic              mclk,     // reference clock
    output pxc_pkg::pxc_mgmt_wr_t  mgmt_wr,  // write strobe and fields
    output logic [4:0]             rd_regad, // read address
    input  wire logic [15:0]       rd_data   // read data
);
    import pxc_pkg::*;
    // idle bus at time zero
    initial
    begin
        mgmt_wr  = '0;
        rd_regad = 5'h00;
    end
    task write(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        mgmt_wr = '{1'b1, pa, ra, d};
        @(negedge mclk);
        // strobe dropped, released data shows its inverse
        mgmt_wr = '{1'b0, pa, ra, ~d};
        // one idle edge before a following call raises the strobe
        @(negedge mclk);
    endtask : write
    // address held across the sampling edge
    task read(input logic [4:0] ra, output logic [15:0] d);
        rd_regad = ra;
        @(negedge mclk);
        d = rd_data;
    endtask : read
endmodule : pxc_mgmt_model

// ---- test/pxc_regs_asserts.sv ----
/* port checker for the control register pair.
   assumes bind onto pxc_regs, one mclk domain. */
`timescale 1ns/100ps
module pxc_regs_asserts (
    input  wire logic               mclk,             // clock
    input  wire logic               rst,              // sync reset
    input  wire logic               strap_clkout_dis, // strap
    input  wire logic [4:0]         local_phyad,      // own address
    input  pxc_pkg::pxc_mgmt_wr_t   mgmt_wr,          // write
    input  wire logic [4:0]         rd_regad,         // read address
    input  wire logic [15:0]        rd_data,          // read data
    input  wire logic               rd_hit,           // read hit
    input  pxc_pkg::pxc_link_stat_t link_stat,        // link status
    input  pxc_pkg::pxc_ctrl_t      ctrl,             // controls
    input  wire logic               soft_reset_out    // soft reset
);
    import pxc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // soft reset request, local address
    sequence s_srst_req;
        mgmt_wr.wr && mgmt_wr.phyad == local_phyad && mgmt_wr.regad == 5'h1c && mgmt_wr.data[9] && !soft_reset_out;
    endsequence
    // broadcast soft reset with broadcast off
    sequence s_bcast_off;
        !$past(mgmt_wr.wr) ##0 mgmt_wr.wr && mgmt_wr.phyad == 5'h1f && local_phyad != 5'h1f
        && !ctrl.broadcast_write_enable && mgmt_wr.regad == 5'h1c && mgmt_wr.data[9] && !soft_reset_out;
    endsequence
    // eight cycles high, then low
    sequence s_srst_run;
        soft_reset_out [*8] ##1 !soft_reset_out;
    endsequence
    a_pat_gated: assert property (!ctrl.pattern_enable_10m |-> ctrl.test_pattern_select == 2'h0)
        else $error("pattern select not zero while disabled");
    a_sync_cond: assert property (ctrl.tx_clk_from_rx |-> $past(link_stat.speed_100 && link_stat.mac_mii_rmii_master))
        else $error("transmit follows recovered clock off conditions");
    a_rxclk_speed: assert property (ctrl.clkout_from_rx |-> $past(link_stat.speed_100))
        else $error("recovered clock on pin outside 100M");
    a_legacy_clk: assert property (ctrl.legacy_pinout |-> ctrl.clkout_enable)
        else $error("legacy mode without clock output");
    a_bcast_off: assert property (s_bcast_off |=> !soft_reset_out)
        else $error("broadcast write taken while disabled");
    a_srst_start: assert property (s_srst_req |=> soft_reset_out)
        else $error("soft reset did not start");
    a_srst_len: assert property ($rose(soft_reset_out) |-> s_srst_run)
        else $error("soft reset length wrong");
    a_rsvd_zero: assert property ($past(rd_regad) == 5'h1c |-> (rd_data & 16'hc1fc) == 16'h0000)
        else $error("reserved bits read nonzero");
endmodule : pxc_regs_asserts
bind pxc_regs pxc_regs_asserts u_chk (.mclk(mclk), .rst(rst), .strap_clkout_dis(strap_clkout_dis),
    .local_phyad(local_phyad), .mgmt_wr(mgmt_wr), .rd_regad(rd_regad), .rd_data(rd_data), .rd_hit(rd_hit),
    .link_stat(link_stat), .ctrl(ctrl), .soft_reset_out(soft_reset_out));

// ---- test/tb_top.sv ----
/* self-checking bench for the control register pair.
   assumes pxc_regs, its bound checker and the management model. */
`timescale 1ns/100ps
module tb_top;
    import pxc_pkg::*;
    logic           mclk, rst, strap_clkout_dis, rd_hit, soft_reset_out; // pins
    logic [4:0]     local_phyad, rd_regad;  // addresses
    logic [15:0]    rd_data, rv;            // read data
    pxc_mgmt_wr_t   mgmt_wr;                // write bus
    pxc_link_stat_t link_stat;              // link status
    pxc_ctrl_t      ctrl;                   // controls
    int             bad_count, checked, cyc, n; // counters
    pxc_regs dut (.mclk(mclk), .rst(rst), .strap_clkout_dis(strap_clkout_dis), .local_phyad(local_phyad),
        .mgmt_wr(mgmt_wr), .rd_regad(rd_regad), .rd_data(rd_data), .rd_hit(rd_hit), .link_stat(link_stat),
        .ctrl(ctrl), .soft_reset_out(soft_reset_out));
    pxc_mgmt_model u_mgmt (.mclk(mclk), .mgmt_wr(mgmt_wr), .rd_regad(rd_regad), .rd_data(rd_data));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // hang guard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            complete_run;
        end
    end
    task complete_run;
        $display("mismatches %0d comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [4:0] a, input logic [15:0] e);
        u_mgmt.read(a, rv);
        chk(rv, e);
    endtask : rd
    // controls settle one edge after the write
    task cchk(input logic [7:0] e);
        @(negedge mclk);
        chk({8'h00, ctrl}, {8'h00, e});
    endtask : cchk
    task t_reset;
        rd(5'h1b, 16'h0000);
        rd(5'h1c, 16'h0002);
        chk({15'h0, rd_hit}, 16'h0001);
        rd(5'h1d, 16'h0000);
        chk({15'h0, rd_hit}, 16'h0000);
        cchk(8'h00);
    endtask : t_reset
    task t_pattern;
        for (int p = 0; p < 4; p++)
        begin
            u_mgmt.write(5'h05, 5'h1b, 16'h0010 | 16'(p));
            cchk(8'h80 | 8'(p << 5));
            rd(5'h1b, 16'h0010 | 16'(p));
        end
        u_mgmt.write(5'h05, 5'h1b, 16'hffe3);
        cchk(8'h00);
        rd(5'h1b, 16'h0003);
    endtask : t_pattern
    task t_general;
        u_mgmt.write(5'h05, 5'h1c, 16'hfdfc);
        cchk(8'h07);
        rd(5'h1c, 16'h3c00);
        link_stat = '{1'b1, 1'b0};
        cchk(8'h0f);
        link_stat = '1;
        cchk(8'h1f);
        u_mgmt.write(5'h05, 5'h1c, 16'h0002);
        cchk(8'h00);
        rd(5'h1c, 16'h0002);
    endtask : t_general
    task t_bcast;
        u_mgmt.write(5'h05, 5'h1c, 16'h0800);
        rd(5'h1c, 16'h0800);
        u_mgmt.write(5'h1f, 5'h1b, 16'h0011);
        rd(5'h1b, 16'h0011);
        u_mgmt.write(5'h05, 5'h1c, 16'h0000);
        rd(5'h1c, 16'h0000);
        u_mgmt.write(5'h1f, 5'h1c, 16'h0a00);
        rd(5'h1c, 16'h0000);
    endtask : t_bcast
    task t_soft;
        u_mgmt.write(5'h05, 5'h1b, 16'h0013);
        u_mgmt.write(5'h05, 5'h1c, 16'h2200);
        // first reset cycle passed during the write's idle edge
        n = 1;
        while (soft_reset_out === 1'b1 && n < 20)
        begin
            n++;
            @(negedge mclk);
        end
        chk(16'(n), 16'h0008);
        rd(5'h1c, 16'h2000);
        rd(5'h1b, 16'h0013);
        chk({8'h00, ctrl}, 16'h00f4);
    endtask : t_soft
    initial
    begin
        rst = 1'b1;
        strap_clkout_dis = 1'b1;
        local_phyad = 5'h05;
        link_stat = '0;
        bad_count = 0;
        checked = 0;
        cyc = 0;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        t_reset;
        t_pattern;
        t_general;
        t_bcast;
        t_soft;
        complete_run;
    end
endmodule : tb_top
